// [design/ubsp_baud_gen.v]
// Purpose: baud divisor registers, prescaler and sync clock edge select
// Assumes: one clock, AXI4-Lite slave, inputs synchronous to clk_sys
// Notes: frame logic lives elsewhere; this block gives rate and edge strobes
//
// Summary of operation
// - Clock polarity matters only in synchronous mode; software keeps it zero otherwise.
// - Polarity 0 shifts out on the rising sync clock edge and samples on falling; 1 swaps.
// - A 12-bit divisor sets the bit rate of transmitter and receiver.
// - High register gives divisor bits 11..8, low register bits 7..0.
// - Divisor bits 15..12 are reserved, read zero, and software writes zero there.
// - Writing the low register reloads the prescaler at once with the new divisor.
// - Divisor zero at normal speed gives a bit rate of the clock over sixteen.
// - Every divisor value is accepted, even those far from the target rate.
// - Double speed in asynchronous mode divides by eight instead of sixteen per bit.
// - Mode select zero is asynchronous, one is synchronous.
`timescale 1ns/1ps
`include "ubsp_consts.vh"

module ubsp_baud_gen #(
    parameter DIV_W = 12
)
(
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // AXI4-Lite write channels
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read channels
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Synchronous clock pin, sampled
    input wire sync_clock_pin,
    // Strobes and settings to the frame logic
    output reg rate_tick,
    output reg bit_tick,
    output reg tx_change_strobe,
    output reg rx_sample_strobe,
    output reg sync_mode_select,
    output reg [DIV_W-1:0] baud_divisor
);

    // Reset release through two flops
    reg rst_meta_r;
    reg rst_n_r;
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    reg [7:0] div_high_r;
    reg [7:0] div_low_r;
    reg clock_edge_polarity_r;
    reg double_speed_r;
    reg [DIV_W-1:0] presc_r;
    reg [DIV_W-1:0] presc_nxt;
    reg [4:0] ovs_r;
    reg pin_prev_r;
    reg have_aw_r;
    reg have_w_r;
    reg [3:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    wire wr_fire;
    wire low_write;
    wire [DIV_W-1:0] new_div;
    wire [4:0] ovs_len;

    // Write fires once address and data both held
    assign wr_fire = have_aw_r && have_w_r && !s_axi_bvalid;
    assign low_write = wr_fire && (aw_addr_r == `UBSP_OFF_DIV_LOW) && w_strb_r[0];
    // high nibble joined with new low byte
    assign new_div = {div_high_r[3:0], w_data_r[7:0]};
    assign ovs_len = (double_speed_r && !sync_mode_select) ? `UBSP_OVS_DOUBLE
                                                           : `UBSP_OVS_NORMAL;

    // Write address and data capture, in either order
    always @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            have_aw_r <= 1'b0;
            have_w_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `UBSP_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !have_aw_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !have_w_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                have_aw_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                have_w_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr_r == `UBSP_OFF_DIV_HIGH || aw_addr_r == `UBSP_OFF_DIV_LOW ||
                    aw_addr_r == `UBSP_OFF_CTRL || aw_addr_r == `UBSP_OFF_STATUS)
                    s_axi_bresp <= `UBSP_RESP_OKAY;
                else
                    s_axi_bresp <= `UBSP_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                have_aw_r <= 1'b0;
                have_w_r <= 1'b0;
            end
        end
    end

    // Register writes
    always @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            div_high_r <= `UBSP_DIV_HIGH_RST;
            div_low_r <= `UBSP_DIV_LOW_RST;
            clock_edge_polarity_r <= 1'b0;
            double_speed_r <= 1'b0;
            sync_mode_select <= 1'b0;
            baud_divisor <= {DIV_W{1'b0}};
        end
        else if (wr_fire && w_strb_r[0])
        begin
            if (aw_addr_r == `UBSP_OFF_DIV_HIGH)
                div_high_r <= {4'h0, w_data_r[3:0]};
            else if (aw_addr_r == `UBSP_OFF_DIV_LOW)
            begin
                div_low_r <= w_data_r[7:0];
                // high bits apply with low write
                baud_divisor <= new_div;
            end
            else if (aw_addr_r == `UBSP_OFF_CTRL)
            begin
                clock_edge_polarity_r <= w_data_r[`UBSP_CTRL_POL_BIT];
                double_speed_r <= w_data_r[`UBSP_CTRL_DBL_BIT];
                sync_mode_select <= w_data_r[`UBSP_CTRL_SYNC_BIT];
            end
        end
    end

    // Prescaler next value
    always @*
    begin
        if (low_write)
            presc_nxt = new_div;
        // reload at zero, else count down
        else if (presc_r == {DIV_W{1'b0}})
            presc_nxt = baud_divisor;
        else
            presc_nxt = presc_r - 1'b1;
    end

    always @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            presc_r <= {DIV_W{1'b0}};
            ovs_r <= 5'h0;
            rate_tick <= 1'b0;
            bit_tick <= 1'b0;
        end
        else
        begin
            presc_r <= presc_nxt;
            rate_tick <= !low_write && (presc_r == {DIV_W{1'b0}});
            bit_tick <= 1'b0;
            if (low_write)
                ovs_r <= 5'h0;
            else if (presc_r == {DIV_W{1'b0}})
            begin
                // one bit per sixteen ticks at normal speed
                if (ovs_r >= ovs_len - 5'h1)
                begin
                    ovs_r <= 5'h0;
                    bit_tick <= !sync_mode_select;
                end
                else
                    ovs_r <= ovs_r + 5'h1;
            end
        end
    end

    // sync clock edges pick shift and sample moments
    always @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            pin_prev_r <= 1'b0;
            tx_change_strobe <= 1'b0;
            rx_sample_strobe <= 1'b0;
        end
        else
        begin
            pin_prev_r <= sync_clock_pin;
            // edges used only in sync mode
            tx_change_strobe <= sync_mode_select &&
                (clock_edge_polarity_r ? (pin_prev_r && !sync_clock_pin)
                                       : (!pin_prev_r && sync_clock_pin));
            rx_sample_strobe <= sync_mode_select &&
                (clock_edge_polarity_r ? (!pin_prev_r && sync_clock_pin)
                                       : (pin_prev_r && !sync_clock_pin));
        end
    end

    // Read channel, one cycle answer
    always @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `UBSP_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `UBSP_RESP_OKAY;
                if (s_axi_araddr == `UBSP_OFF_DIV_HIGH)
                    s_axi_rdata <= {24'h0, div_high_r};
                else if (s_axi_araddr == `UBSP_OFF_DIV_LOW)
                    s_axi_rdata <= {24'h0, div_low_r};
                else if (s_axi_araddr == `UBSP_OFF_CTRL)
                    s_axi_rdata <= {29'h0, sync_mode_select, double_speed_r,
                                    clock_edge_polarity_r};
                else if (s_axi_araddr == `UBSP_OFF_STATUS)
                    s_axi_rdata <= {{(32-DIV_W){1'b0}}, presc_r};
                else
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `UBSP_RESP_SLVERR;
                end
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// [pkg/ubsp_consts.vh]
// Purpose: constants for the baud generator and clock polarity block
// Assumes: AXI4-Lite, 32-bit data, word aligned registers
// Notes: offsets are byte addresses
`ifndef UBSP_CONSTS_VH
`define UBSP_CONSTS_VH
`define UBSP_OFF_DIV_HIGH 4'h0
`define UBSP_OFF_DIV_LOW 4'h4
`define UBSP_OFF_CTRL 4'h8
`define UBSP_OFF_STATUS 4'hc
`define UBSP_DIV_HIGH_RST 8'h00
`define UBSP_DIV_LOW_RST 8'h00
`define UBSP_CTRL_RST 3'h0
`define UBSP_CTRL_POL_BIT 0
`define UBSP_CTRL_DBL_BIT 1
`define UBSP_CTRL_SYNC_BIT 2
`define UBSP_OVS_NORMAL 5'h10
`define UBSP_OVS_DOUBLE 5'h08
`define UBSP_RESP_OKAY 2'h0
`define UBSP_RESP_SLVERR 2'h2
`endif

// [bench/ubsp_peer_model.sv]
// Purpose: far-side serial peer making the sync clock
// Assumes: the clock moves only while run is high
// Notes: HALF is the half period in clk_sys cycles
`timescale 1ns/1ps
module ubsp_peer_model #(parameter HALF = 6)
(
    // Clock and frame enable
    input wire clk_sys,
    input wire run,
    // Sync clock towards the block
    output logic sync_clock_pin = 1'b0
);
    int cnt = 0;
    always @(posedge clk_sys)
    begin
        cnt <= run ? (cnt + 1) % HALF : 0;
        if (!run)
            sync_clock_pin <= 1'b0;
        else if (cnt == HALF - 1)
            sync_clock_pin <= ~sync_clock_pin;
    end
endmodule

// [bench/ubsp_baud_gen_props.sv]
// Purpose: port checks for the baud generator
// Assumes: one clock domain
// Notes: tick gaps are not judged across a write
`timescale 1ns/1ps
module ubsp_baud_gen_props #(parameter DIV_W = 12)
(
    // Clock, reset and bus
    input wire clk_sys,
    input wire reset_n,
    input wire s_axi_wvalid,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // Rate and edge side
    input wire sync_clock_pin,
    input wire rate_tick,
    input wire bit_tick,
    input wire tx_change_strobe,
    input wire rx_sample_strobe,
    input wire sync_mode_select,
    input wire [DIV_W-1:0] baud_divisor
);
    logic [DIV_W:0] gap_r;
    logic ok_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Cycles since last tick, void around writes
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gap_r <= '0;
            ok_r <= 1'b0;
        end
        else
        begin
            gap_r <= rate_tick ? '0 : gap_r + 1'b1;
            ok_r <= (s_axi_wvalid || s_axi_bvalid) ? 1'b0 : (ok_r || rate_tick);
        end
    end
    tick_gap_a: assert property (
        rate_tick && ok_r |-> gap_r == baud_divisor) else $error("rate tick gap");
    sync_no_bit_a: assert property (
        sync_mode_select && $past(sync_mode_select) |-> !bit_tick) else $error("bit tick in sync");
    async_quiet_a: assert property (
        !sync_mode_select && !$past(sync_mode_select) |-> !(tx_change_strobe || rx_sample_strobe))
        else $error("edge strobe in async");
    edge_strobe_a: assert property (
        sync_mode_select && $past(sync_mode_select) && $past(sync_clock_pin)
        != $past(sync_clock_pin, 2) |-> tx_change_strobe ^ rx_sample_strobe)
        else $error("pin edge without strobe");
    strobe_cause_a: assert property (
        tx_change_strobe || rx_sample_strobe |-> $past(sync_clock_pin)
        != $past(sync_clock_pin, 2)) else $error("strobe without pin edge");
    one_kind_a: assert property (
        !(tx_change_strobe && rx_sample_strobe)) else $error("both strobes");
    div_update_a: assert property (
        $changed(baud_divisor) |-> s_axi_bvalid && !$past(s_axi_bvalid))
        else $error("divisor moved without write");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    cover property (rate_tick && ok_r);
    cover property (tx_change_strobe);
    cover property (rx_sample_strobe);
endmodule
bind ubsp_baud_gen ubsp_baud_gen_props #(.DIV_W(DIV_W)) i_props (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .sync_clock_pin(sync_clock_pin),
    .rate_tick(rate_tick),
    .bit_tick(bit_tick),
    .tx_change_strobe(tx_change_strobe),
    .rx_sample_strobe(rx_sample_strobe),
    .sync_mode_select(sync_mode_select),
    .baud_divisor(baud_divisor)
);

// [bench/usart_baud_and_sync_polarity_test.sv]
// Purpose: self-checking bench for the baud generator
// Assumes: bench is the AXI4-Lite master, peer model makes the sync clock
// Notes: expected bus answers queue up and a monitor pops them
`timescale 1ns/1ps
`include "ubsp_consts.vh"
module usart_baud_and_sync_polarity_test;
    logic clk_sys = 0, reset_n = 0, run = 0, pol = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire sync_clock_pin, rate_tick, bit_tick, tx_change_strobe, rx_sample_strobe;
    wire sync_mode_select;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [11:0] baud_divisor;
    logic [33:0] q[$];
    int num_errors = 0, n_tests = 0, cyc = 0, n, d, n_tx = 0, n_rx = 0;
    ubsp_baud_gen i_dut (.*);
    ubsp_peer_model i_peer (.clk_sys(clk_sys), .run(run), .sync_clock_pin(sync_clock_pin));
    initial forever #4 clk_sys = ~clk_sys;
    task finish_test;
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task cmp_bus(input logic [33:0] g, input logic [33:0] e);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task cmp_cnt(input int g, input int e);
        cmp_bus(g, e);
    endtask
    // Write cycle, address and data offered together
    task wr(input logic [3:0] a, input logic [31:0] v);
        bit ad, wd;
        ad = 0;
        wd = 0;
        @(posedge clk_sys);
        q.push_back({`UBSP_RESP_OKAY, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(ad && wd))
        begin
            @(posedge clk_sys);
            if (s_axi_awready)
                s_axi_awvalid <= 0;
            if (s_axi_wready)
                s_axi_wvalid <= 0;
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
        end
        while (!s_axi_bvalid)
            @(posedge clk_sys);
        s_axi_bready <= 0;
    endtask
    task rd(input logic [3:0] a, input logic [33:0] e);
        @(posedge clk_sys);
        q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do
            @(posedge clk_sys);
        while (!s_axi_arready);
        s_axi_arvalid <= 0;
        while (!s_axi_rvalid)
            @(posedge clk_sys);
        s_axi_rready <= 0;
    endtask
    // Cycles between two ticks of the chosen kind
    task gap(input bit s, output int c);
        c = 0;
        @(posedge clk_sys);
        while (!(s ? bit_tick : rate_tick))
            @(posedge clk_sys);
        do
        begin
            @(posedge clk_sys);
            c++;
        end
        while (!(s ? bit_tick : rate_tick));
    endtask
    // Bus answers and sync edge strobes
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            finish_test;
        end
        if (s_axi_bvalid && s_axi_bready)
            cmp_bus({s_axi_bresp, 32'h0}, q.pop_front());
        if (s_axi_rvalid && s_axi_rready)
            cmp_bus({s_axi_rresp, s_axi_rdata}, q.pop_front());
        if (run && (tx_change_strobe || rx_sample_strobe))
        begin
            n_tx <= n_tx + tx_change_strobe;
            n_rx <= n_rx + rx_sample_strobe;
            cmp_bus(tx_change_strobe, sync_clock_pin ^ pol);
        end
    end
    initial
    begin
        void'($urandom(27394));
        repeat (6) @(posedge clk_sys);
        reset_n <= 1;
        repeat (4) @(posedge clk_sys);
        rd(`UBSP_OFF_DIV_HIGH, 0);
        rd(`UBSP_OFF_DIV_LOW, 0);
        rd(4'h2, {`UBSP_RESP_SLVERR, 32'h0});
        wr(`UBSP_OFF_DIV_HIGH, 32'h05);
        rd(`UBSP_OFF_DIV_HIGH, 32'h5);
        cmp_bus(baud_divisor, 0);
        d = $urandom % 256;
        wr(`UBSP_OFF_DIV_LOW, d);
        cmp_bus(baud_divisor, 12'h500 | d);
        rd(`UBSP_OFF_DIV_LOW, d);
        gap(0, n);
        cmp_cnt(n, (12'h500 | d) + 1);
        wr(`UBSP_OFF_DIV_HIGH, 0);
        cmp_bus(baud_divisor, 12'h500 | d);
        wr(`UBSP_OFF_DIV_LOW, 3);
        n = 0;
        while (!rate_tick && n < 9999)
        begin
            @(posedge clk_sys);
            n++;
        end
        cmp_cnt(n < 8, 1);
        for (int k = 0; k < 4; k++)
        begin
            d = k < 2 ? 0 : $urandom % 4;
            wr(`UBSP_OFF_CTRL, k[0] << `UBSP_CTRL_DBL_BIT);
            wr(`UBSP_OFF_DIV_LOW, d);
            gap(0, n);
            cmp_cnt(n, d + 1);
            gap(1, n);
            cmp_cnt(n, (d + 1) * (k[0] ? 8 : 16));
        end
        // Sync runs with both polarities, then one async run with the pin toggling
        for (int k = 0; k < 3; k++)
        begin
            pol = k[0];
            wr(`UBSP_OFF_CTRL, k < 2 ? 32'h4 | k : 32'h0);
            rd(`UBSP_OFF_CTRL, k < 2 ? 32'h4 | k : 32'h0);
            n_tx = 0;
            n_rx = 0;
            run <= 1;
            repeat (60) @(posedge clk_sys);
            cmp_bus(sync_mode_select, k < 2);
            run <= 0;
            repeat (4) @(posedge clk_sys);
            cmp_cnt(k < 2 ? (n_tx > 3 && n_rx > 3) : (n_tx + n_rx == 0), 1);
        end
        finish_test;
    end
endmodule
